// ---- hdl/acc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module acc_top
    import acc_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] CLK_SRC_IN,
    input wire logic [3:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [3:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    output acc_pkg::acc_setting_t SETTING_OUT,
    output logic CONV_CLK_EN_OUT,
    output logic PIN_DISABLE_CH9_OUT,
    output logic PIN_DISABLE_CH8_OUT
);
    import acc_pkg::*;

    // Divider lookup: code to terminal count
    function automatic logic [2:0] div_limit(input logic [1:0] code);
        case (code)
            2'h0: div_limit = 3'h0;
            2'h1: div_limit = 3'h1;
            2'h2: div_limit = 3'h3;
            default: div_limit = 3'h7;
        endcase
    endfunction

    // Register map decode: offset names a register
    function automatic logic addr_known(input logic [3:0] addr);
        addr_known = (addr == CFG_OFFSET) | (addr == PIN_OFFSET)
            | (addr == STAT_OFFSET) | (addr == CNT_OFFSET);
    endfunction

    logic [7:0] cfg_r;
    logic [7:0] pin_r;
    logic [3:0] src_meta_r;
    logic [3:0] src_sync_r;
    logic [3:0] src_prev_r;
    logic [2:0] div_cnt_r;
    logic [2:0] div_cnt_nxt;
    logic [15:0] tick_cnt_r;
    logic conv_en_r;
    logic aw_have_r;
    logic w_have_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    acc_bus_state_t wr_state_r;
    acc_bus_state_t rd_state_r;
    logic [1:0] bresp_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic aw_rdy_r;
    logic w_rdy_r;
    logic ar_rdy_r;
    logic bvalid_r;
    logic rvalid_r;

    // Input clock source select and edge detection
    wire [1:0] clk_sel = cfg_r[CLK_SEL_HI:CLK_SEL_LO];
    wire src_level = src_sync_r[clk_sel];
    wire src_edge = src_level & ~src_prev_r[clk_sel];
    wire [1:0] div_sel = cfg_r[DIV_HI:DIV_LO];
    wire div_wrap = (div_cnt_r >= div_limit(div_sel));
    wire [2:0] div_inc = div_cnt_r + 3'h1;

    // Divider next count
    always_comb
    begin
        div_cnt_nxt = div_cnt_r;
        if (src_edge)
        begin
            div_cnt_nxt = div_wrap ? 3'h0 : div_inc;
        end
    end

    // Synchronise clock source pins
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            src_meta_r <= 4'h0;
            src_sync_r <= 4'h0;
            src_prev_r <= 4'h0;
        end
        else
        begin
            src_meta_r <= CLK_SRC_IN;
            src_sync_r <= src_meta_r;
            src_prev_r <= src_sync_r;
        end
    end

    // Conversion clock enable divider
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            div_cnt_r <= 3'h0;
            conv_en_r <= 1'b0;
            tick_cnt_r <= 16'h0000;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            conv_en_r <= src_edge & div_wrap;
            if (src_edge & div_wrap)
            begin
                tick_cnt_r <= tick_cnt_r + 16'h0001;
            end
        end
    end

    // Write channel handshakes
    wire aw_take = AWVALID_IN & aw_rdy_r;
    wire w_take = WVALID_IN & w_rdy_r;
    wire aw_full = aw_have_r | aw_take;
    wire w_full = w_have_r | w_take;
    wire [3:0] wr_addr = aw_take ? AWADDR_IN : aw_addr_r;
    wire [31:0] wr_data = w_take ? WDATA_IN : w_data_r;
    wire [3:0] wr_strb = w_take ? WSTRB_IN : w_strb_r;
    wire wr_go = aw_full & w_full & (wr_state_r == ACC_IDLE);
    wire wr_cfg = wr_go & (wr_addr == CFG_OFFSET) & wr_strb[0];
    wire wr_pin = wr_go & (wr_addr == PIN_OFFSET) & wr_strb[0];
    wire wr_ok = addr_known(wr_addr);
    wire wr_idle_nxt = (wr_state_r == ACC_RESP) ? BREADY_IN : ~wr_go;
    wire aw_keep = aw_full & ~wr_go;
    wire w_keep = w_full & ~wr_go;

    // Write address and data capture
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            aw_have_r <= aw_keep;
            w_have_r <= w_keep;
            if (aw_take)
            begin
                aw_addr_r <= AWADDR_IN;
            end
            if (w_take)
            begin
                w_data_r <= WDATA_IN;
                w_strb_r <= WSTRB_IN;
            end
        end
    end

    // Write response
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            wr_state_r <= ACC_IDLE;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            case (wr_state_r)
                ACC_IDLE:
                begin
                    if (wr_go)
                    begin
                        wr_state_r <= ACC_RESP;
                        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                ACC_RESP:
                begin
                    if (BREADY_IN)
                    begin
                        wr_state_r <= ACC_IDLE;
                    end
                end
                default: wr_state_r <= ACC_IDLE;
            endcase
        end
    end

    // Configuration and pin control registers
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            cfg_r <= CFG_RESET;
            pin_r <= PIN_RESET;
        end
        else
        begin
            if (wr_cfg)
            begin
                cfg_r <= wr_data[7:0];
            end
            if (wr_pin)
            begin
                pin_r <= wr_data[7:0] & PIN_WRITE_MASK;
            end
        end
    end

    // Read data select
    wire [1:0] mode = cfg_r[MODE_HI:MODE_LO];
    wire mode_ok = (mode == MODE_8BIT) | (mode == MODE_10BIT);
    wire [31:0] stat_word = {24'h00_0000, conv_en_r, 3'h0, mode_ok,
        div_cnt_r};
    wire [31:0] rd_word =
        (ARADDR_IN == CFG_OFFSET) ? {24'h00_0000, cfg_r} :
        (ARADDR_IN == PIN_OFFSET) ? {24'h00_0000, pin_r} :
        (ARADDR_IN == STAT_OFFSET) ? stat_word :
        (ARADDR_IN == CNT_OFFSET) ? {16'h0000, tick_cnt_r} :
        32'h0000_0000;
    wire rd_ok = addr_known(ARADDR_IN);
    wire rd_take = ARVALID_IN & ar_rdy_r;
    wire rd_idle_nxt = (rd_state_r == ACC_RESP) ? RREADY_IN : ~rd_take;

    // Read channel
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rd_state_r <= ACC_IDLE;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            case (rd_state_r)
                ACC_IDLE:
                begin
                    if (rd_take)
                    begin
                        rd_state_r <= ACC_RESP;
                        rdata_r <= rd_word;
                        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                ACC_RESP:
                begin
                    if (RREADY_IN)
                    begin
                        rd_state_r <= ACC_IDLE;
                    end
                end
                default: rd_state_r <= ACC_IDLE;
            endcase
        end
    end

    // Registered ready and valid flags, so bus outputs come from flops
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            aw_rdy_r <= 1'b0;
            w_rdy_r <= 1'b0;
            ar_rdy_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            aw_rdy_r <= wr_idle_nxt & ~aw_keep;
            w_rdy_r <= wr_idle_nxt & ~w_keep;
            ar_rdy_r <= rd_idle_nxt;
            bvalid_r <= ~wr_idle_nxt;
            rvalid_r <= ~rd_idle_nxt;
        end
    end

    // Decoded setting to the converter core
    acc_setting_t setting_r;
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            setting_r <= '0;
            PIN_DISABLE_CH9_OUT <= 1'b0;
            PIN_DISABLE_CH8_OUT <= 1'b0;
        end
        else
        begin
            setting_r.low_power <= cfg_r[LOW_POWER_BIT];
            setting_r.long_sample <= cfg_r[LONG_SAMPLE_BIT];
            setting_r.res_10bit <= (mode == MODE_10BIT);
            setting_r.mode_valid <= mode_ok;
            setting_r.clk_sel <= clk_sel;
            setting_r.div_sel <= div_sel;
            PIN_DISABLE_CH9_OUT <= pin_r[PIN_CH9_BIT];
            PIN_DISABLE_CH8_OUT <= pin_r[PIN_CH8_BIT];
        end
    end

    // Outputs from flip-flops
    assign SETTING_OUT = setting_r;
    assign CONV_CLK_EN_OUT = conv_en_r;
    assign AWREADY_OUT = aw_rdy_r;
    assign WREADY_OUT = w_rdy_r;
    assign BVALID_OUT = bvalid_r;
    assign BRESP_OUT = bresp_r;
    assign ARREADY_OUT = ar_rdy_r;
    assign RDATA_OUT = rdata_r;
    assign RRESP_OUT = rresp_r;
    assign RVALID_OUT = rvalid_r;
endmodule
`default_nettype wire

// ---- hdl/acc_pkg.sv ----
package acc_pkg;
    // Register byte offsets on the bus
    localparam logic [3:0] CFG_OFFSET = 4'h0;
    localparam logic [3:0] PIN_OFFSET = 4'h4;
    localparam logic [3:0] STAT_OFFSET = 4'h8;
    localparam logic [3:0] CNT_OFFSET = 4'hC;
    // Field positions in the configuration register
    localparam int LOW_POWER_BIT = 7;
    localparam int DIV_HI = 6;
    localparam int DIV_LO = 5;
    localparam int LONG_SAMPLE_BIT = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 2;
    localparam int CLK_SEL_HI = 1;
    localparam int CLK_SEL_LO = 0;
    // Field positions in the pin control register
    localparam int PIN_CH9_BIT = 1;
    localparam int PIN_CH8_BIT = 0;
    localparam logic [7:0] PIN_WRITE_MASK = 8'h03;
    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] PIN_RESET = 8'h00;
    // Resolution codes
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded converter setting
    typedef struct packed {
        logic low_power;
        logic long_sample;
        logic res_10bit;
        logic mode_valid;
        logic [1:0] clk_sel;
        logic [1:0] div_sel;
    } acc_setting_t;

    // Bus transaction state
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_RESP = 2'b01
    } acc_bus_state_t;
endpackage

// ---- bench/acc_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module acc_top_monitor
    import acc_pkg::*;
(
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    input wire logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    input wire logic WREADY_OUT,
    input wire acc_pkg::acc_setting_t SETTING_OUT,
    input wire logic CONV_CLK_EN_OUT,
    input wire logic PIN_DISABLE_CH9_OUT,
    input wire logic PIN_DISABLE_CH8_OUT
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // Low byte write taken on both channels
    wire logic wr_w = AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
        && WSTRB_IN[0];
    wire logic cfg_w = wr_w && AWADDR_IN == CFG_OFFSET;
    wire logic pin_w = wr_w && AWADDR_IN == PIN_OFFSET;
    // Written fields show two edges after the write
    low_power_a: assert property (cfg_w |-> ##2
        SETTING_OUT.low_power == $past(WDATA_IN[7], 2)) else $error("lp");
    divide_sel_a: assert property (cfg_w |-> ##2
        SETTING_OUT.div_sel == $past(WDATA_IN[6:5], 2)) else $error("div");
    long_sample_a: assert property (cfg_w |-> ##2
        SETTING_OUT.long_sample == $past(WDATA_IN[4], 2)) else $error("ls");
    res_mode_a: assert property (cfg_w && !WDATA_IN[2] |-> ##2
        SETTING_OUT.res_10bit == $past(WDATA_IN[3], 2)) else $error("res");
    mode_valid_a: assert property (cfg_w |-> ##2
        SETTING_OUT.mode_valid == !$past(WDATA_IN[2], 2)) else $error("mv");
    clock_src_a: assert property (cfg_w |-> ##2
        SETTING_OUT.clk_sel == $past(WDATA_IN[1:0], 2)) else $error("src");
    pin_nine_a: assert property (pin_w |-> ##2
        PIN_DISABLE_CH9_OUT == $past(WDATA_IN[1], 2)) else $error("ch9");
    pin_eight_a: assert property (pin_w |-> ##2
        PIN_DISABLE_CH8_OUT == $past(WDATA_IN[0], 2)) else $error("ch8");
    pulse_once_a: assert property (CONV_CLK_EN_OUT |=>
        !CONV_CLK_EN_OUT) else $error("pulse too long");
    // Main scenarios reached
    cover property (cfg_w);
    cover property (pin_w);
    cover property (CONV_CLK_EN_OUT);
endmodule
bind acc_top acc_top_monitor mon (.MCLK_IN, .RST_N_IN, .AWADDR_IN,
    .AWVALID_IN, .AWREADY_OUT, .WDATA_IN, .WSTRB_IN, .WVALID_IN,
    .WREADY_OUT, .SETTING_OUT, .CONV_CLK_EN_OUT, .PIN_DISABLE_CH9_OUT,
    .PIN_DISABLE_CH8_OUT);
`default_nettype wire

// ---- bench/acc_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module acc_top_tb_top;
    import acc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] clk_src = 4'h0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, conv_en, p9, p8;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    acc_setting_t setting;
    int n_fail = 0;
    int checked = 0;
    int i;
    logic [7:0] vals [4] = '{8'hFF, 8'h84, 8'h28, 8'h53};
    acc_top uut (.MCLK_IN(clk), .RST_N_IN(rst_n), .CLK_SRC_IN(clk_src),
        .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
        .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
        .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
        .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .RVALID_OUT(rvalid), .RREADY_IN(rready), .SETTING_OUT(setting),
        .CONV_CLK_EN_OUT(conv_en), .PIN_DISABLE_CH9_OUT(p9),
        .PIN_DISABLE_CH8_OUT(p8));
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    task automatic report_and_stop;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Bus write, holds each channel until taken
    task automatic wr(input logic [3:0] a, input logic [7:0] v, logic s);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h00_0000, v};
        wstrb <= {3'b000, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1 && bready)
            begin
                bready <= 1'b0;
                r = bresp;
            end
        end while (n < 50 && (awvalid || wvalid || bready));
        if (n >= 50)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask
    // Bus read into d and r
    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready)
            begin
                rready <= 1'b0;
                d = rdata;
                r = rresp;
            end
        end while (n < 50 && (arvalid || rready));
        if (n >= 50)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask
    function automatic acc_setting_t exp_set(input logic [7:0] v);
        return '{v[7], v[4], v[3:2] == MODE_10BIT, !v[2], v[1:0], v[6:5]};
    endfunction
    // Count pulses over 16 edges of the selected source
    task automatic div_run(input logic [1:0] s);
        int k;
        int p;
        p = 0;
        wr(CFG_OFFSET, {1'b0, s, 3'b000, s}, 1'b1);
        repeat (8) @(posedge clk);
        for (k = 0; k < 160; k++)
        begin
            @(posedge clk);
            clk_src[s] <= k < 128 && k % 8 < 4;
            if (conv_en === 1'b1)
                p++;
        end
        `CHK(p, 16 >> s)
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(CFG_OFFSET);
        `CHK(d, 32'h0000_0000)
        rd(PIN_OFFSET);
        `CHK(d, 32'h0000_0000)
        `CHK(setting, exp_set(8'h00))
        `CHK({p9, p8}, 2'b00)
        $display("reset test end");
        for (i = 0; i < 4; i++)
        begin
            wr(CFG_OFFSET, vals[i], 1'b1);
            rd(CFG_OFFSET);
            `CHK(d, {24'h00_0000, vals[i]})
            `CHK(setting, exp_set(vals[i]))
        end
        $display("config test end");
        wr(PIN_OFFSET, 8'hFF, 1'b1);
        rd(PIN_OFFSET);
        `CHK(d, 32'h0000_0003)
        `CHK({p9, p8}, 2'b11)
        wr(PIN_OFFSET, 8'h01, 1'b1);
        wr(PIN_OFFSET, 8'h02, 1'b0);
        `CHK(r, RESP_OKAY)
        rd(PIN_OFFSET);
        `CHK(d, 32'h0000_0001)
        `CHK({p9, p8}, 2'b01)
        rd(4'h2);
        `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
        $display("pin test end");
        for (i = 0; i < 4; i++)
            div_run(i[1:0]);
        wr(STAT_OFFSET, 8'hFF, 1'b1);
        `CHK(r, RESP_OKAY)
        rd(STAT_OFFSET);
        `CHK(d, 32'h0000_0008)
        rd(CNT_OFFSET);
        `CHK(d, 32'h0000_001E)
        $display("divider test end");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(CFG_OFFSET);
        `CHK(d, 32'h0000_0000)
        `CHK(p8, 1'b0)
        rd(CNT_OFFSET);
        `CHK(d, 32'h0000_0000)
        report_and_stop();
    end
endmodule
`default_nettype wire
